// ===== logic/cfb_pkg.sv
package cfb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices and command codes.
    localparam int NUM_REGS   = 6;
    localparam int IDX_VOUT   = 0;
    localparam int IDX_IOUT   = 1;
    localparam int IDX_INPUT  = 2;
    localparam int IDX_TEMP   = 3;
    localparam int IDX_CML    = 4;
    localparam int IDX_VENDOR = 5;

    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_STATUS = 8'h7a;
    localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS = 8'h7b;
    localparam logic [7:0] CMD_INPUT_SUPPLY_STATUS   = 8'h7c;
    localparam logic [7:0] CMD_TEMPERATURE_STATUS    = 8'h7d;
    localparam logic [7:0] CMD_COMMUNICATION_STATUS  = 8'h7e;
    localparam logic [7:0] CMD_VENDOR_FAULT_STATUS   = 8'h80;

    localparam logic [7:0] CMD_CODE [NUM_REGS] = '{
        CMD_OUTPUT_VOLTAGE_STATUS, CMD_OUTPUT_CURRENT_STATUS, CMD_INPUT_SUPPLY_STATUS,
        CMD_TEMPERATURE_STATUS, CMD_COMMUNICATION_STATUS, CMD_VENDOR_FAULT_STATUS};

    ////////////////////////////////////////////////////////////////////////////
    // Bit positions.
    localparam int BIT_OV_FAULT     = 7;
    localparam int BIT_OV_WARN      = 6;
    localparam int BIT_UV_WARN      = 5;
    localparam int BIT_UV_FAULT     = 4;
    localparam int BIT_SETPOINT     = 3;
    localparam int BIT_TON_TIMEOUT  = 2;
    localparam int BIT_OC_FAULT     = 7;
    localparam int BIT_OC_WARN      = 5;
    localparam int BIT_LOW_INPUT    = 3;
    localparam int BIT_OT_FAULT     = 7;
    localparam int BIT_OT_WARN      = 6;
    localparam int BIT_BAD_CMD      = 7;
    localparam int BIT_BAD_DATA     = 6;
    localparam int BIT_PEC_FAIL     = 5;
    localparam int BIT_MEM_FAULT    = 4;
    localparam int BIT_OTHER_COMM   = 1;
    localparam int BIT_BG_OVERTEMP  = 7;
    localparam int BIT_FSM_ZERO     = 6;
    localparam int BIT_FSM_MULTI    = 5;
    localparam int BIT_ADDR_FAIL    = 4;
    localparam int BIT_SYNC_LIVE    = 3;

    // Bits that are write-one-to-clear; the same bits are the only alert sources.
    localparam logic [7:0] RW1C_MASK [NUM_REGS] = '{
        8'hfc, 8'ha0, 8'h08, 8'hc0, 8'hf2, 8'h90};
    // Bits that hardware latches (the sync bit is live and composed on read).
    localparam logic [7:0] LATCH_MASK [NUM_REGS] = '{
        8'hfc, 8'ha0, 8'h08, 8'hc0, 8'hf2, 8'hf0};
    localparam logic [7:0] STATUS_RESET [NUM_REGS] = '{
        8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] ALERT_MASK_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Thresholds and counts.
    localparam int TEMP_HYST_DEGC  = 20;
    localparam int ADDR_FAIL_LIMIT = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Comparator and strap levels from the analog side (asynchronous).
    typedef struct packed {
        logic ov_fault;
        logic ov_warn;
        logic uv_warn;
        logic uv_fault;
        logic oc_fault;
        logic oc_warn;
        logic vin_above_on;
        logic vin_below_off;
        logic bg_overtemp;
        logic loop_slave;
        logic clock_slave;
        logic ext_sync_present;
        logic sync_sensed;
    } cfb_analog_s;

    // One-cycle event pulses from the command decoder on mclk.
    typedef struct packed {
        logic setpoint_range;
        logic turn_on_timeout;
        logic bad_cmd;
        logic bad_data;
        logic pec_fail;
        logic mem_fault;
        logic other_comm;
    } cfb_event_s;

endpackage

// ===== logic/cfb_status_bank.sv
`timescale 1ns/1ns
// How it works
// - Output above overvoltage fault limit sets vout bit 7.
// - Output above overvoltage warning limit sets vout bit 6.
// - Output below undervoltage warning limit sets vout bit 5.
// - Output below undervoltage fault limit sets vout bit 4.
// - Out-of-range setpoint write attempt sets vout bit 3.
// - Turn-on timeout event sets vout bit 2.
// - Loop slave configuration holds every vout bit at zero.
// - Host writes one to clear; stored mask bit gates each writable flag onto alert.
// - Overcurrent fault sets current bit 7, overcurrent warning sets bit 5.
// - Low-input bit set from power-up until input first exceeds turn-on, no alert.
// - After first turn-on, each drop below turn-off latches low-input and alerts.
// - Temperature at or above fault/warning limit sets temperature bit 7/6.
// - A cleared temperature flag re-sets unless temperature fell 20 degrees below limit.
// - Bad command code sets comm bit 7; bad data sets comm bit 6.
// - Failed packet error check sets comm bit 5.
// - Internal memory fault sets comm bit 4; other comm fault sets bit 1.
// - Bandgap temperature over shutdown threshold sets vendor bit 7.
// - All-zero operation state sets vendor bit 6, never alerts.
// - Multi-hot operation state sets vendor bit 5, never alerts.
// - Four consecutive address resolve failures set vendor bit 4 and alert.
// - Vendor bit 3 shows live sync fault, unlatched, never alerts.
// - Summary bits follow detailed flags and cannot be written directly.
module cfb_status_bank #(
    parameter int TEMP_W  = 11,
    parameter int STATE_W = 8
) (
    // Clock and reset.
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    // Command port from the bus decoder.
    input  wire logic [7:0]           cmd_code,
    input  wire logic                 wr_stb,
    input  wire logic                 mask_wr_stb,
    input  wire logic [7:0]           wr_data,
    input  wire logic                 rd_stb,
    input  wire logic                 clear_faults_stb,
    output logic      [7:0]           rd_data,
    output logic                      rd_ack,
    output logic                      rd_hit,
    // Detector inputs.
    input  wire cfb_pkg::cfb_analog_s ana_in,
    input  wire cfb_pkg::cfb_event_s  ev_in,
    input  wire logic [TEMP_W-1:0]    temp_reading,
    input  wire logic [TEMP_W-1:0]    ot_fault_limit,
    input  wire logic [TEMP_W-1:0]    ot_warn_limit,
    input  wire logic [STATE_W-1:0]   op_state,
    input  wire logic                 addr_sample_stb,
    input  wire logic                 addr_sample_ok,
    // Alert request and summary bits.
    output logic                      smb_alert_req,
    output logic      [5:0]           summary_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Parameter checks.
    if (STATE_W < 2 || TEMP_W < 6)
    begin : g_param_chk
        $error("STATE_W must be at least 2 and TEMP_W must hold the hysteresis span");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage.
    cfb_pkg::cfb_analog_s ana_meta_reg;
    cfb_pkg::cfb_analog_s ana_reg;
    logic [7:0]           status_reg [cfb_pkg::NUM_REGS];
    logic [7:0]           mask_reg   [cfb_pkg::NUM_REGS];
    logic [7:0]           set_vec    [cfb_pkg::NUM_REGS];
    logic [7:0]           clr_vec    [cfb_pkg::NUM_REGS];
    logic [7:0]           view_vec   [cfb_pkg::NUM_REGS];
    logic [cfb_pkg::NUM_REGS-1:0] wr_hit;
    logic                 vin_started_reg;
    logic                 vin_first_on;
    logic [1:0]           ot_hold_reg;
    logic [1:0]           ot_at_limit;
    logic [1:0]           ot_recovered;
    logic [2:0]           addr_fail_cnt_reg;
    logic                 addr_fail_hit;
    logic                 sync_live_reg;
    logic                 fsm_zero;
    logic                 fsm_multi;
    logic                 alert_next;
    logic [7:0]           rd_data_next;
    logic                 rd_hit_next;

    ////////////////////////////////////////////////////////////////////////////
    // Analog levels cross into mclk through two flops; only the second is read.
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ana_meta_reg <= '0;
            ana_reg      <= '0;
        end
        else
        begin
            ana_meta_reg <= ana_in;
            ana_reg      <= ana_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Temperature compare; signed, one bit wider so limit minus hysteresis cannot wrap.
    logic signed [TEMP_W:0] temp_s;
    logic signed [TEMP_W:0] lim_s [2];
    logic signed [TEMP_W:0] hyst_s;
    assign hyst_s   = (TEMP_W+1)'(cfb_pkg::TEMP_HYST_DEGC);
    assign temp_s   = {temp_reading[TEMP_W-1], temp_reading};
    assign lim_s[0] = {ot_warn_limit[TEMP_W-1], ot_warn_limit};
    assign lim_s[1] = {ot_fault_limit[TEMP_W-1], ot_fault_limit};
    always_comb
    begin
        for (int k = 0; k < 2; k++)
        begin
            ot_at_limit[k]  = temp_s >= lim_s[k];
            ot_recovered[k] = temp_s <= (lim_s[k] - hyst_s);
        end
    end

    // A hold bit remembers an over-limit episode until the 20 degree recovery.
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ot_hold_reg <= '0;
        end
        else
        begin
            ot_hold_reg <= ot_at_limit | (ot_hold_reg & ~ot_recovered);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input start tracking; the low-input bit only latches after first turn-on.
    assign vin_first_on = !vin_started_reg && ana_reg.vin_above_on;
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            vin_started_reg <= 1'b0;
        end
        else if (vin_first_on)
        begin
            vin_started_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address resolve failures; a passing sample restarts the run of four.
    assign addr_fail_hit = addr_sample_stb && !addr_sample_ok
                           && (addr_fail_cnt_reg == 3'(cfb_pkg::ADDR_FAIL_LIMIT - 1));
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            addr_fail_cnt_reg <= '0;
        end
        else if (addr_sample_stb)
        begin
            addr_fail_cnt_reg <= (addr_sample_ok || addr_fail_hit)
                                 ? 3'h0 : addr_fail_cnt_reg + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Illegal operation state detection on the one-hot vector.
    assign fsm_zero  = (op_state == '0);
    assign fsm_multi = ((op_state & (op_state - STATE_W'(1))) != '0);

    // Sync fault is a plain live level, registered only to keep timing clean.
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync_live_reg <= 1'b0;
        end
        else
        begin
            sync_live_reg <= ana_reg.clock_slave ? !ana_reg.ext_sync_present
                                                 : !ana_reg.sync_sensed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Set terms per register.
    always_comb
    begin
        for (int i = 0; i < cfb_pkg::NUM_REGS; i++)
        begin
            set_vec[i] = '0;
        end
        set_vec[cfb_pkg::IDX_VOUT][cfb_pkg::BIT_OV_FAULT]     = ana_reg.ov_fault;
        set_vec[cfb_pkg::IDX_VOUT][cfb_pkg::BIT_OV_WARN]      = ana_reg.ov_warn;
        set_vec[cfb_pkg::IDX_VOUT][cfb_pkg::BIT_UV_WARN]      = ana_reg.uv_warn;
        set_vec[cfb_pkg::IDX_VOUT][cfb_pkg::BIT_UV_FAULT]     = ana_reg.uv_fault;
        set_vec[cfb_pkg::IDX_VOUT][cfb_pkg::BIT_SETPOINT]     = ev_in.setpoint_range;
        set_vec[cfb_pkg::IDX_VOUT][cfb_pkg::BIT_TON_TIMEOUT]  = ev_in.turn_on_timeout;
        if (ana_reg.loop_slave)
        begin
            set_vec[cfb_pkg::IDX_VOUT] = '0;
        end
        set_vec[cfb_pkg::IDX_IOUT][cfb_pkg::BIT_OC_FAULT]     = ana_reg.oc_fault;
        set_vec[cfb_pkg::IDX_IOUT][cfb_pkg::BIT_OC_WARN]      = ana_reg.oc_warn;
        set_vec[cfb_pkg::IDX_INPUT][cfb_pkg::BIT_LOW_INPUT]   =
            vin_started_reg && ana_reg.vin_below_off;
        set_vec[cfb_pkg::IDX_TEMP][cfb_pkg::BIT_OT_FAULT]     =
            ot_at_limit[1] || ot_hold_reg[1];
        set_vec[cfb_pkg::IDX_TEMP][cfb_pkg::BIT_OT_WARN]      =
            ot_at_limit[0] || ot_hold_reg[0];
        set_vec[cfb_pkg::IDX_CML][cfb_pkg::BIT_BAD_CMD]       = ev_in.bad_cmd;
        set_vec[cfb_pkg::IDX_CML][cfb_pkg::BIT_BAD_DATA]      = ev_in.bad_data;
        set_vec[cfb_pkg::IDX_CML][cfb_pkg::BIT_PEC_FAIL]      = ev_in.pec_fail;
        set_vec[cfb_pkg::IDX_CML][cfb_pkg::BIT_MEM_FAULT]     = ev_in.mem_fault;
        set_vec[cfb_pkg::IDX_CML][cfb_pkg::BIT_OTHER_COMM]    = ev_in.other_comm;
        set_vec[cfb_pkg::IDX_VENDOR][cfb_pkg::BIT_BG_OVERTEMP] = ana_reg.bg_overtemp;
        set_vec[cfb_pkg::IDX_VENDOR][cfb_pkg::BIT_FSM_ZERO]   = fsm_zero;
        set_vec[cfb_pkg::IDX_VENDOR][cfb_pkg::BIT_FSM_MULTI]  = fsm_multi;
        set_vec[cfb_pkg::IDX_VENDOR][cfb_pkg::BIT_ADDR_FAIL]  = addr_fail_hit;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clear terms: write-one on writable bits, or the clear-faults command.
    // The read-only illegal-state bits only fall on clear-faults.
    always_comb
    begin
        for (int i = 0; i < cfb_pkg::NUM_REGS; i++)
        begin
            wr_hit[i]  = wr_stb && (cmd_code == cfb_pkg::CMD_CODE[i]);
            clr_vec[i] = (wr_hit[i] ? (wr_data & cfb_pkg::RW1C_MASK[i]) : 8'h00)
                         | (clear_faults_stb ? cfb_pkg::LATCH_MASK[i] : 8'h00);
        end
        if (ana_reg.loop_slave)
        begin
            clr_vec[cfb_pkg::IDX_VOUT] = 8'hff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flag storage; a set in the same cycle as a clear wins so no event is lost.
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < cfb_pkg::NUM_REGS; i++)
            begin
                status_reg[i] <= cfb_pkg::STATUS_RESET[i];
            end
        end
        else
        begin
            for (int i = 0; i < cfb_pkg::NUM_REGS; i++)
            begin
                status_reg[i] <= ((status_reg[i] & ~clr_vec[i]) | set_vec[i])
                                 & cfb_pkg::LATCH_MASK[i];
            end
            // Low input is held set until first turn-on, then released once.
            if (!vin_started_reg)
            begin
                status_reg[cfb_pkg::IDX_INPUT][cfb_pkg::BIT_LOW_INPUT] <= !vin_first_on;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alert mask copies; only writable bit positions hold a mask.
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < cfb_pkg::NUM_REGS; i++)
            begin
                mask_reg[i] <= cfb_pkg::ALERT_MASK_RESET;
            end
        end
        else if (mask_wr_stb)
        begin
            for (int i = 0; i < cfb_pkg::NUM_REGS; i++)
            begin
                if (cmd_code == cfb_pkg::CMD_CODE[i])
                begin
                    mask_reg[i] <= wr_data & cfb_pkg::RW1C_MASK[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Readable view with the live sync bit merged; alert from unmasked sources.
    always_comb
    begin
        alert_next   = 1'b0;
        rd_data_next = 8'h00;
        rd_hit_next  = 1'b0;
        for (int i = 0; i < cfb_pkg::NUM_REGS; i++)
        begin
            view_vec[i] = status_reg[i];
            // Start-up low input must not raise the alert.
            if (i != cfb_pkg::IDX_INPUT || vin_started_reg)
            begin
                alert_next = alert_next
                    | (|(status_reg[i] & cfb_pkg::RW1C_MASK[i] & ~mask_reg[i]));
            end
        end
        view_vec[cfb_pkg::IDX_VENDOR][cfb_pkg::BIT_SYNC_LIVE] = sync_live_reg;
        for (int i = 0; i < cfb_pkg::NUM_REGS; i++)
        begin
            if (cmd_code == cfb_pkg::CMD_CODE[i])
            begin
                rd_data_next = view_vec[i];
                rd_hit_next  = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs; summary bits are pure functions of the flags.
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_data       <= 8'h00;
            rd_ack        <= 1'b0;
            rd_hit        <= 1'b0;
            smb_alert_req <= 1'b0;
            summary_out   <= '0;
        end
        else
        begin
            rd_ack        <= rd_stb;
            rd_hit        <= rd_stb && rd_hit_next;
            rd_data       <= rd_stb ? rd_data_next : 8'h00;
            smb_alert_req <= alert_next;
            for (int i = 0; i < cfb_pkg::NUM_REGS; i++)
            begin
                summary_out[i] <= |view_vec[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence four_fails_s;
        addr_sample_stb && !addr_sample_ok
            && addr_fail_cnt_reg == 3'(cfb_pkg::ADDR_FAIL_LIMIT - 1);
    endsequence

    ovf_sets_a: assert property (ana_reg.ov_fault && !ana_reg.loop_slave
        |=> status_reg[cfb_pkg::IDX_VOUT][cfb_pkg::BIT_OV_FAULT])
        else $error("overvoltage fault flag not set");
    loop_slave_zero_a: assert property (ana_reg.loop_slave
        |=> status_reg[cfb_pkg::IDX_VOUT] == 8'h00)
        else $error("vout flags not held at zero for loop slave");
    write_clear_a: assert property (wr_hit[cfb_pkg::IDX_IOUT]
        && wr_data[cfb_pkg::BIT_OC_WARN] && !ana_reg.oc_warn && !clear_faults_stb
        |=> !status_reg[cfb_pkg::IDX_IOUT][cfb_pkg::BIT_OC_WARN])
        else $error("write one did not clear the flag");
    masked_quiet_a: assert property (vin_started_reg && (alert_next == 1'b0)
        |=> !smb_alert_req)
        else $error("alert raised with every source masked");
    low_in_start_a: assert property (!vin_started_reg
        && status_reg[cfb_pkg::IDX_VOUT] == 8'h00 && status_reg[cfb_pkg::IDX_IOUT] == 8'h00
        && status_reg[cfb_pkg::IDX_TEMP] == 8'h00 && status_reg[cfb_pkg::IDX_CML] == 8'h00
        && status_reg[cfb_pkg::IDX_VENDOR] == 8'h00
        |-> status_reg[cfb_pkg::IDX_INPUT][cfb_pkg::BIT_LOW_INPUT] ##1 !smb_alert_req)
        else $error("low input misbehaved before first turn-on");
    low_in_latch_a: assert property (vin_started_reg && ana_reg.vin_below_off
        && mask_reg[cfb_pkg::IDX_INPUT] == 8'h00
        |=> status_reg[cfb_pkg::IDX_INPUT][cfb_pkg::BIT_LOW_INPUT] ##1 smb_alert_req)
        else $error("low input not latched or not alerted");
    temp_rearm_a: assert property (ot_hold_reg[1] && !ot_recovered[1]
        |=> status_reg[cfb_pkg::IDX_TEMP][cfb_pkg::BIT_OT_FAULT])
        else $error("temperature fault flag not re-set before recovery");
    pec_sets_a: assert property (ev_in.pec_fail
        |=> status_reg[cfb_pkg::IDX_CML][cfb_pkg::BIT_PEC_FAIL])
        else $error("packet error flag not set");
    fsm_zero_a: assert property (op_state == '0
        |=> status_reg[cfb_pkg::IDX_VENDOR][cfb_pkg::BIT_FSM_ZERO])
        else $error("illegal zero state flag not set");
    addr_fail_a: assert property (four_fails_s
        |=> status_reg[cfb_pkg::IDX_VENDOR][cfb_pkg::BIT_ADDR_FAIL])
        else $error("address failure flag not set after four fails");
    sync_live_a: assert property (rd_stb && cmd_code == cfb_pkg::CMD_VENDOR_FAULT_STATUS
        |=> rd_data[cfb_pkg::BIT_SYNC_LIVE] == $past(sync_live_reg))
        else $error("sync bit does not follow the live level");
    unmapped_zero_a: assert property (rd_stb && !rd_hit_next
        |=> rd_ack && !rd_hit && rd_data == 8'h00)
        else $error("unmapped read not answered with zero");

endmodule

// ===== verif/cfb_host.sv
`timescale 1ns/1ns
// Host model: one request at a time, each strobe lasts exactly one cycle.
module cfb_host (
    // Clock.
    input  wire logic       mclk,
    // Requests.
    output logic      [7:0] cmd,
    output logic      [7:0] wd,
    output logic      [2:0] stb,
    output logic            rd_stb,
    // Answer.
    input  wire logic [7:0] rdd
);
    // Quiet until the bench asks for traffic.
    initial {cmd, wd, stb, rd_stb} = '0;
    // Kind bit 0 clears by writing ones, bit 1 loads the mask, bit 2 clears all.
    task automatic wr(input logic [2:0] k, input logic [7:0] c, d);
        @(posedge mclk);
        cmd <= c;
        wd  <= d;
        stb <= k;
        @(posedge mclk);
        stb <= 3'h0;
    endtask
    // Data is taken at the edge where the one-cycle acknowledge stands.
    task automatic rd(input logic [7:0] c, output logic [7:0] d);
        @(posedge mclk);
        cmd    <= c;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        @(posedge mclk);
        d = rdd;
    endtask
endmodule

// ===== verif/test_converter_fault_status_bank.sv
`timescale 1ns/1ns
// Detectors are driven here; every register access goes through the host model.
module test_converter_fault_status_bank;
    logic                 mclk = 1'b0;
    logic                 sys_rst = 1'b1;
    logic [7:0]           cmd, wd, rdd, d, op = 8'h01;
    logic [2:0]           stb;
    logic                 rd_stb, alert, ack, hit, as = 1'b0, ao = 1'b0;
    logic [5:0]           sum;
    logic [10:0]          temp = 11'h000;
    cfb_pkg::cfb_analog_s ana = 13'h0001;
    cfb_pkg::cfb_event_s  ev = '0;
    int                   fails = 0, checked = 0;
    cfb_status_bank u_cfb_status_bank (.mclk, .sys_rst, .cmd_code(cmd), .wr_stb(stb[0]),
        .mask_wr_stb(stb[1]), .wr_data(wd), .rd_stb, .clear_faults_stb(stb[2]),
        .rd_data(rdd), .rd_ack(ack), .rd_hit(hit), .ana_in(ana), .ev_in(ev),
        .temp_reading(temp), .ot_fault_limit(11'h05a), .ot_warn_limit(11'h050), .op_state(op),
        .addr_sample_stb(as), .addr_sample_ok(ao), .smb_alert_req(alert), .summary_out(sum));
    cfb_host u_cfb_host (.mclk, .cmd, .wd, .stb, .rd_stb, .rdd);
    ////////////////////////////////////////////////////////////////////////////
    // Compare, count and report at once.
    task automatic chk(input string n, input logic [7:0] e, g);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rc(input logic [7:0] c, e);
        u_cfb_host.rd(c, d);
        chk($sformatf("reg %h", c), e, d);
        chk("ack hit", {6'h00, 1'b1, c != 8'h7f}, {6'h00, ack, hit});
    endtask
    task automatic w(input logic [2:0] k, input logic [7:0] c, e);
        u_cfb_host.wr(k, c, e);
    endtask
    // Analog levels pass two sync flops, so four cycles are allowed to land.
    task automatic an(input logic [12:0] v);
        @(posedge mclk) ana <= v;
        repeat (4) @(posedge mclk);
    endtask
    task automatic ep(input logic [6:0] v);
        @(posedge mclk) ev <= v;
        @(posedge mclk) ev <= '0;
    endtask
    // Alert follows its flag one cycle later.
    task automatic al(input logic e);
        repeat (2) @(posedge mclk);
        chk("alert", {7'h00, e}, {7'h00, alert});
    endtask
    task automatic smp(input logic ok);
        @(posedge mclk);
        as <= 1'b1;
        ao <= ok;
        @(posedge mclk) as <= 1'b0;
    endtask
    task give_verdict;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial forever #5 mclk = ~mclk;
    // Watchdog: the sequence needs well under a thousand cycles.
    initial
    begin
        #50000;
        fails++;
        give_verdict();
    end
    // Main sequence.
    initial
    begin
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int i = 0; i < cfb_pkg::NUM_REGS; i++)
            rc(cfb_pkg::CMD_CODE[i], cfb_pkg::STATUS_RESET[i]);
        rc(8'h7f, 8'h00);
        chk("summary", 8'h04, {2'b00, sum});
        w(3'h1, 8'h7c, 8'h08);
        rc(8'h7c, 8'h08);
        al(1'b0);
        ep(7'h7f);
        rc(8'h7a, 8'h0c);
        rc(8'h7e, 8'hf2);
        chk("summary", 8'h15, {2'b00, sum});
        al(1'b1);
        w(3'h1, 8'h7a, 8'hff);
        w(3'h1, 8'h7e, 8'hff);
        rc(8'h7e, 8'h00);
        w(3'h2, 8'h7a, 8'hfc);
        ep(7'h60);
        al(1'b0);
        rc(8'h7a, 8'h0c);
        $display("test events done");
        an(13'h1f91);
        an(13'h0001);
        rc(8'h7a, 8'hfc);
        rc(8'h7b, 8'ha0);
        rc(8'h80, 8'h80);
        w(3'h1, 8'h7a, 8'hff);
        w(3'h1, 8'h7b, 8'hff);
        an(13'h1009);
        rc(8'h7a, 8'h00);
        an(13'h0001);
        @(posedge mclk) temp <= 11'h05a;
        rc(8'h7d, 8'hc0);
        @(posedge mclk) temp <= 11'h046;
        w(3'h1, 8'h7d, 8'hc0);
        rc(8'h7d, 8'h40);
        @(posedge mclk) temp <= 11'h032;
        w(3'h1, 8'h7d, 8'hc0);
        rc(8'h7d, 8'h00);
        $display("test detectors done");
        @(posedge mclk) op <= 8'h00;
        @(posedge mclk) op <= 8'h03;
        @(posedge mclk) op <= 8'h01;
        w(3'h1, 8'h80, 8'hff);
        rc(8'h80, 8'h60);
        al(1'b0);
        for (int i = 0; i < 7; i++)
            smp(i == 3);
        rc(8'h80, 8'h60);
        smp(1'b0);
        rc(8'h80, 8'h70);
        al(1'b1);
        w(3'h4, 8'h00, 8'h00);
        rc(8'h80, 8'h00);
        an(13'h0000);
        rc(8'h80, 8'h08);
        al(1'b0);
        an(13'h0001);
        rc(8'h80, 8'h00);
        $display("test vendor done");
        an(13'h0041);
        an(13'h0001);
        rc(8'h7c, 8'h00);
        an(13'h0021);
        an(13'h0001);
        rc(8'h7c, 8'h08);
        al(1'b1);
        w(3'h1, 8'h7c, 8'h08);
        rc(8'h7c, 8'h00);
        $display("test input done");
        give_verdict();
    end
endmodule
